// >>> gopc_pkg.sv
// gopc_pkg: constants and carrier types of the rate-sensor output path configuration block.
// assumes a 250 MHz core clock and an 8-bit register port driven by a serial-bus front end.
package gopc_pkg;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] GOPC_ADDR_Y_TRIM_HIGH = 8'h15;
  localparam logic [7:0] GOPC_ADDR_Y_TRIM_LOW = 8'h16;
  localparam logic [7:0] GOPC_ADDR_Z_TRIM_HIGH = 8'h17;
  localparam logic [7:0] GOPC_ADDR_Z_TRIM_LOW = 8'h18;
  localparam logic [7:0] GOPC_ADDR_DIVISOR = 8'h19;
  localparam logic [7:0] GOPC_ADDR_CONFIG = 8'h1A;
  localparam logic [7:0] GOPC_ADDR_RATE_CONFIG = 8'h1B;
  localparam logic [7:0] GOPC_ADDR_QUEUE_STATUS = 8'h70;

  // --------------------------------------------------------------------------
  // field positions and writable masks
  // --------------------------------------------------------------------------
  localparam int GOPC_CFG_QMODE_POS = 6;
  localparam int GOPC_CFG_SYNC_LSB = 3;
  localparam int GOPC_CFG_LPF_LSB = 0;
  localparam int GOPC_RCFG_BYP_LSB = 0;
  localparam logic [7:0] GOPC_CFG_WMASK = 8'h7F;
  localparam logic [7:0] GOPC_RCFG_WMASK = 8'h03;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] GOPC_TRIM_RST = 8'h00;
  localparam logic [7:0] GOPC_DIVISOR_RST = 8'h00;
  localparam logic [7:0] GOPC_CONFIG_RST = 8'h00;
  localparam logic [7:0] GOPC_RATE_CONFIG_RST = 8'h00;

  // --------------------------------------------------------------------------
  // frame-sync tag targets and filter settings
  // --------------------------------------------------------------------------
  localparam logic [2:0] GOPC_SYNC_NONE = 3'h0;
  localparam logic [2:0] GOPC_SYNC_TEMP = 3'h1;
  localparam logic [2:0] GOPC_SYNC_X = 3'h2;
  localparam logic [2:0] GOPC_SYNC_Y = 3'h3;
  localparam logic [2:0] GOPC_SYNC_Z = 3'h4;
  localparam logic [2:0] GOPC_LPF_250HZ = 3'h0;
  localparam logic [2:0] GOPC_LPF_176HZ = 3'h1;
  localparam logic [2:0] GOPC_LPF_92HZ = 3'h2;
  localparam logic [2:0] GOPC_LPF_WIDE = 3'h7;
  localparam logic [1:0] GOPC_BYP_NONE = 2'h0;
  localparam logic [1:0] GOPC_BYP_3281HZ = 2'h2;

  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int GOPC_CLK_HZ = 250000000;
  localparam int GOPC_BASE_RATE_HZ = 1000;
  localparam int GOPC_MID_RATE_HZ = 8000;
  localparam int GOPC_FAST_RATE_HZ = 32000;
  localparam int GOPC_BASE_CYCLES = GOPC_CLK_HZ / GOPC_BASE_RATE_HZ;
  localparam int GOPC_MID_CYCLES = GOPC_CLK_HZ / GOPC_MID_RATE_HZ;
  localparam int GOPC_FAST_CYCLES = GOPC_CLK_HZ / GOPC_FAST_RATE_HZ;

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } gopc_sample_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gopc_reg_req_type;

endpackage

// >>> gopc_queue_mem.sv
// gopc_queue_mem: sample storage of the output queue, one write and one read port.
// assumes the owner keeps the pointers; read data appear one clock after the read strobe.
`timescale 1ns/1ns
module gopc_queue_mem #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic ref_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_ff [DEPTH];

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (WIDTH < 1 || DEPTH < 2 || DEPTH > (1 << AW)) begin : g_bad_size
    $error("gopc_queue_mem: DEPTH must fit AW address bits, WIDTH at least 1");
  end

  // --------------------------------------------------------------------------
  // storage, no reset so it maps onto ram
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
    if (rd_en_i) begin
      rd_data_o <= mem_ff[rd_addr_i];
    end
  end

endmodule

// >>> gopc_core.sv
// gopc_core: output sample path of a three-axis rate sensor: filter choice, user trim,
// output rate divider, frame-sync tagging and the sample queue with its full policy.
// assumes raw samples and x trim come from logic on ref_clk_i; frame_sync_input_i is a pin.
//
// Function
// - add signed 16-bit trim before output register
// - trim high byte bits 15:8, low 7:0
// - output rate is base over divisor plus one
// - divisor base rate is one kilohertz
// - divisor only with bypass 00, setting 1..6
// - divided strobe refreshes outputs and pushes queue
// - full queue: mode 1 drops, 0 overwrites oldest
// - sync select tags bit 0 of chosen word
// - sync latched on toggle, held until strobe
// - lowpass setting used only with bypass bits 00
// - bypass bits run 32 kHz wide paths
// - settings 0,1,2,7 pick bandwidth and rate
// - bypass bits at rate config bits 1:0
`timescale 1ns/1ns
module gopc_core
  import gopc_pkg::*;
#(
  parameter int BASE_CYCLES = GOPC_BASE_CYCLES,
  parameter int MID_CYCLES = GOPC_MID_CYCLES,
  parameter int FAST_CYCLES = GOPC_FAST_CYCLES,
  parameter int QDEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire gopc_reg_req_type reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire gopc_sample_type raw_sample_i,
  input wire logic [15:0] x_rate_trim_i,
  input wire logic frame_sync_input_i,
  output gopc_sample_type rate_out_o,
  output logic sample_strobe_o,
  input wire logic queue_pop_i,
  output gopc_sample_type queue_data_o,
  output logic queue_data_valid_o,
  output logic queue_empty_o,
  output logic queue_full_o
);

  localparam int QAW = $clog2(QDEPTH);
  localparam int CW = $clog2(BASE_CYCLES + 1);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (QDEPTH < 2 || (1 << QAW) != QDEPTH) begin : g_bad_depth
    $error("gopc_core: QDEPTH must be a power of two, at least 2");
  end
  if (FAST_CYCLES < 1 || MID_CYCLES < FAST_CYCLES || BASE_CYCLES < MID_CYCLES) begin : g_bad_rate
    $error("gopc_core: rate periods must satisfy 1 <= fast <= mid <= base");
  end

  typedef struct packed {
    logic [7:0] y_trim_high;
    logic [7:0] y_trim_low;
    logic [7:0] z_trim_high;
    logic [7:0] z_trim_low;
    logic [7:0] divisor;
    logic [7:0] config_reg;
    logic [7:0] rate_config;
    logic [7:0] rdata;
    logic [CW-1:0] base_cnt;
    logic [CW-1:0] mid_cnt;
    logic [CW-1:0] fast_cnt;
    logic [7:0] div_cnt;
    logic [2:0] sync_pipe;
    logic sync_held;
    logic sync_value;
    gopc_sample_type filt;
    gopc_sample_type out;
    logic strobe;
    logic [QAW-1:0] wr_ptr;
    logic [QAW-1:0] rd_ptr;
    logic [QAW:0] count;
    logic qvalid;
  } gopc_state_type;

  gopc_state_type st_ff;
  gopc_state_type nxt_st;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // one first-order lowpass step; the shift sets the corner relative to the update rate
  function automatic logic [15:0] lpf_step(input logic [15:0] acc, input logic [15:0] smp,
                                           input logic [2:0] shift);
    logic signed [16:0] diff;
    logic signed [16:0] step;
    diff = $signed({smp[15], smp}) - $signed({acc[15], acc});
    step = diff >>> shift;
    return acc + step[15:0];
  endfunction

  // free-running period counter, wraps at the given period
  function automatic logic [CW-1:0] period_next(input logic [CW-1:0] cnt, input int period);
    if (cnt >= CW'(period - 1)) begin
      return '0;
    end
    return cnt + CW'(1);
  endfunction

  // --------------------------------------------------------------------------
  // queue storage
  // --------------------------------------------------------------------------
  logic q_push;
  logic q_pop;

  gopc_queue_mem #(
    .WIDTH($bits(gopc_sample_type)),
    .DEPTH(QDEPTH),
    .AW(QAW)
  ) u_queue_mem (
    .ref_clk_i(ref_clk_i),
    .wr_en_i(q_push),
    .wr_addr_i(st_ff.wr_ptr),
    .wr_data_i(nxt_st.out),
    .rd_en_i(q_pop),
    .rd_addr_i(st_ff.rd_ptr),
    .rd_data_o(queue_data_o)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  logic [1:0] byp;
  logic [2:0] lpf;
  logic [2:0] sync_sel;
  logic qmode;
  logic tick_base;
  logic tick_mid;
  logic tick_fast;
  logic path_tick;
  logic div_active;
  logic [2:0] shift;
  logic sync_toggle;
  logic tag_bit;
  logic q_full;
  logic [15:0] y_trim;
  logic [15:0] z_trim;

  always_comb begin
    nxt_st = st_ff;
    byp = st_ff.rate_config[GOPC_RCFG_BYP_LSB +: 2];
    lpf = st_ff.config_reg[GOPC_CFG_LPF_LSB +: 3];
    sync_sel = st_ff.config_reg[GOPC_CFG_SYNC_LSB +: 3];
    qmode = st_ff.config_reg[GOPC_CFG_QMODE_POS];
    y_trim = {st_ff.y_trim_high, st_ff.y_trim_low};
    z_trim = {st_ff.z_trim_high, st_ff.z_trim_low};

    // rate ticks; the 32 kHz period rounds down since the clock does not divide evenly
    tick_base = (st_ff.base_cnt == '0);
    tick_mid = (st_ff.mid_cnt == '0);
    tick_fast = (st_ff.fast_cnt == '0);
    nxt_st.base_cnt = period_next(st_ff.base_cnt, BASE_CYCLES);
    nxt_st.mid_cnt = period_next(st_ff.mid_cnt, MID_CYCLES);
    nxt_st.fast_cnt = period_next(st_ff.fast_cnt, FAST_CYCLES);

    // filter path and its internal rate
    shift = 3'h0;
    path_tick = tick_base;
    if (byp[0]) begin
      path_tick = tick_fast;
    end else if (byp == GOPC_BYP_3281HZ) begin
      path_tick = tick_fast;
      shift = 3'h1;
    end else begin
      case (lpf)
        GOPC_LPF_250HZ: begin
          path_tick = tick_mid;
          shift = 3'h2;
        end
        GOPC_LPF_176HZ: begin
          path_tick = tick_base;
          shift = 3'h1;
        end
        GOPC_LPF_92HZ: begin
          path_tick = tick_base;
          shift = 3'h2;
        end
        GOPC_LPF_WIDE: begin
          path_tick = tick_mid;
          shift = 3'h1;
        end
        default: begin
          path_tick = tick_base;
          shift = 3'h2;
        end
      endcase
    end
    if (path_tick) begin
      if (byp[0]) begin
        nxt_st.filt = raw_sample_i;
      end else begin
        nxt_st.filt.temp = lpf_step(st_ff.filt.temp, raw_sample_i.temp, shift);
        nxt_st.filt.x = lpf_step(st_ff.filt.x, raw_sample_i.x, shift);
        nxt_st.filt.y = lpf_step(st_ff.filt.y, raw_sample_i.y, shift);
        nxt_st.filt.z = lpf_step(st_ff.filt.z, raw_sample_i.z, shift);
      end
    end

    // output rate divider, ignored outside bypass 00 and setting 1..6
    div_active = (byp == GOPC_BYP_NONE) && (lpf != 3'h0) && (lpf != 3'h7);
    nxt_st.strobe = 1'b0;
    if (!div_active) begin
      nxt_st.div_cnt = 8'h00;
      nxt_st.strobe = path_tick;
    end else if (tick_base) begin
      nxt_st.strobe = (st_ff.div_cnt == 8'h00);
      nxt_st.div_cnt = (st_ff.div_cnt >= st_ff.divisor) ? 8'h00 : st_ff.div_cnt + 8'h01;
    end

    // frame sync: three-stage pin sampler, change accepted when last two agree
    nxt_st.sync_pipe = {st_ff.sync_pipe[1:0], frame_sync_input_i};
    sync_toggle = (st_ff.sync_pipe[2] == st_ff.sync_pipe[1]) && (st_ff.sync_pipe[1] != st_ff.sync_value);
    if (st_ff.strobe) begin
      nxt_st.sync_held = 1'b0;
    end
    if (sync_toggle && !st_ff.sync_held) begin
      nxt_st.sync_value = st_ff.sync_pipe[1];
      nxt_st.sync_held = 1'b1;
    end
    tag_bit = st_ff.sync_value;

    // output registers refresh on the divided strobe
    if (st_ff.strobe) begin
      nxt_st.out.temp = st_ff.filt.temp;
      nxt_st.out.x = st_ff.filt.x + x_rate_trim_i;
      nxt_st.out.y = st_ff.filt.y + y_trim;
      nxt_st.out.z = st_ff.filt.z + z_trim;
      case (sync_sel)
        GOPC_SYNC_TEMP: nxt_st.out.temp[0] = tag_bit;
        GOPC_SYNC_X: nxt_st.out.x[0] = tag_bit;
        GOPC_SYNC_Y: nxt_st.out.y[0] = tag_bit;
        GOPC_SYNC_Z: nxt_st.out.z[0] = tag_bit;
        default: nxt_st.out.temp = st_ff.filt.temp;
      endcase
    end

    // queue: pop frees a slot in the same cycle, so push then never sees it full
    q_pop = queue_pop_i && (st_ff.count != '0);
    q_full = (st_ff.count == (QAW + 1)'(QDEPTH)) && !q_pop;
    q_push = st_ff.strobe && !(q_full && qmode);
    nxt_st.qvalid = q_pop;
    if (q_pop) begin
      nxt_st.rd_ptr = st_ff.rd_ptr + QAW'(1);
    end
    if (q_push) begin
      nxt_st.wr_ptr = st_ff.wr_ptr + QAW'(1);
      if (q_full) begin
        nxt_st.rd_ptr = st_ff.rd_ptr + QAW'(1);
      end
    end
    nxt_st.count = st_ff.count + (QAW + 1)'(q_push && !q_full) - (QAW + 1)'(q_pop);

    // register port: writes, then registered read data for one cycle
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        GOPC_ADDR_Y_TRIM_HIGH: nxt_st.y_trim_high = reg_req_i.wdata;
        GOPC_ADDR_Y_TRIM_LOW: nxt_st.y_trim_low = reg_req_i.wdata;
        GOPC_ADDR_Z_TRIM_HIGH: nxt_st.z_trim_high = reg_req_i.wdata;
        GOPC_ADDR_Z_TRIM_LOW: nxt_st.z_trim_low = reg_req_i.wdata;
        GOPC_ADDR_DIVISOR: nxt_st.divisor = reg_req_i.wdata;
        GOPC_ADDR_CONFIG: nxt_st.config_reg = reg_req_i.wdata & GOPC_CFG_WMASK;
        GOPC_ADDR_RATE_CONFIG: nxt_st.rate_config = reg_req_i.wdata & GOPC_RCFG_WMASK;
        default: nxt_st.divisor = st_ff.divisor;
      endcase
    end
    nxt_st.rdata = 8'h00;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        GOPC_ADDR_Y_TRIM_HIGH: nxt_st.rdata = st_ff.y_trim_high;
        GOPC_ADDR_Y_TRIM_LOW: nxt_st.rdata = st_ff.y_trim_low;
        GOPC_ADDR_Z_TRIM_HIGH: nxt_st.rdata = st_ff.z_trim_high;
        GOPC_ADDR_Z_TRIM_LOW: nxt_st.rdata = st_ff.z_trim_low;
        GOPC_ADDR_DIVISOR: nxt_st.rdata = st_ff.divisor;
        GOPC_ADDR_CONFIG: nxt_st.rdata = st_ff.config_reg;
        GOPC_ADDR_RATE_CONFIG: nxt_st.rdata = st_ff.rate_config;
        GOPC_ADDR_QUEUE_STATUS: nxt_st.rdata = 8'(st_ff.count);
        default: nxt_st.rdata = 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
      st_ff.y_trim_high <= GOPC_TRIM_RST;
      st_ff.y_trim_low <= GOPC_TRIM_RST;
      st_ff.z_trim_high <= GOPC_TRIM_RST;
      st_ff.z_trim_low <= GOPC_TRIM_RST;
      st_ff.divisor <= GOPC_DIVISOR_RST;
      st_ff.config_reg <= GOPC_CONFIG_RST;
      st_ff.rate_config <= GOPC_RATE_CONFIG_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign reg_rdata_o = st_ff.rdata;
  assign rate_out_o = st_ff.out;
  assign sample_strobe_o = st_ff.strobe;
  assign queue_data_valid_o = st_ff.qvalid;
  assign queue_empty_o = (st_ff.count == '0);
  assign queue_full_o = (st_ff.count == (QAW + 1)'(QDEPTH));

endmodule

// >>> gopc_host_model.sv
// gopc_host_model: host side of the register port, one request per call.
// assumes the block answers a read in the cycle after the strobe and never stalls.
`timescale 1ns/1ns
module gopc_host_model
  import gopc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [7:0] reg_rdata_i,
  output gopc_reg_req_type reg_req_o
);
  initial reg_req_o = '0;
  // strobes drop at the next edge, so a following call starts one cycle later
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    reg_req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_i);
    reg_req_o <= '0;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    reg_req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_i);
    reg_req_o <= '0;
    #1;
    d = reg_rdata_i;
  endtask
endmodule

// >>> gopc_core_monitor.sv
// gopc_core_monitor: port-level assertions of the output path block.
// assumes it is bound into gopc_core; one clock, synchronous active-low reset.
`timescale 1ns/1ns
module gopc_core_monitor
  import gopc_pkg::*;
#(
  parameter int FAST_CYCLES = GOPC_FAST_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire gopc_reg_req_type reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire gopc_sample_type rate_out_o,
  input wire logic sample_strobe_o,
  input wire logic queue_pop_i,
  input wire logic queue_data_valid_o,
  input wire logic queue_empty_o,
  input wire logic queue_full_o
);
  // --------------------------------------------------------------------------
  // helper state
  // --------------------------------------------------------------------------
  int gap_ff;
  logic [7:0] div_ff;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      gap_ff <= FAST_CYCLES;
      div_ff <= GOPC_DIVISOR_RST;
    end else begin
      // saturates so a long idle stretch cannot wrap into a false short gap
      gap_ff <= sample_strobe_o ? 1 : ((gap_ff < 65535) ? gap_ff + 1 : gap_ff);
      if (reg_req_i.wr && reg_req_i.addr == GOPC_ADDR_DIVISOR) begin
        div_ff <= reg_req_i.wdata;
      end
    end
  end
  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_idle_zero_a: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == 8'h00)
    else $error("read data not zero outside answer");
  div_readback_a: assert property ($past(reg_req_i.rd) && $past(reg_req_i.addr) == GOPC_ADDR_DIVISOR
    |-> reg_rdata_o == $past(div_ff)) else $error("divisor readback wrong");
  cfg_reserved_a: assert property ($past(reg_req_i.rd) && $past(reg_req_i.addr) == GOPC_ADDR_CONFIG
    |-> reg_rdata_o[7] == 1'b0) else $error("config reserved bit set");
  rcfg_reserved_a: assert property ($past(reg_req_i.rd) && $past(reg_req_i.addr) == GOPC_ADDR_RATE_CONFIG
    |-> reg_rdata_o[7:2] == 6'h00) else $error("rate config reserved bits set");
  strobe_gap_a: assert property (sample_strobe_o |-> gap_ff >= FAST_CYCLES)
    else $error("strobes too close");
  out_hold_a: assert property (!$past(sample_strobe_o) |-> $stable(rate_out_o))
    else $error("output changed without strobe");
  push_fill_a: assert property (sample_strobe_o |=> !queue_empty_o)
    else $error("strobe did not push queue");
  pop_valid_a: assert property (queue_pop_i && !queue_empty_o |=> queue_data_valid_o)
    else $error("pop gave no valid");
  empty_pop_a: assert property (queue_pop_i && queue_empty_o |=> !queue_data_valid_o)
    else $error("pop on empty gave valid");
  full_keep_a: assert property (queue_full_o && sample_strobe_o && !queue_pop_i |=> queue_full_o)
    else $error("full queue lost an entry on push");
endmodule
bind gopc_core gopc_core_monitor #(.FAST_CYCLES(FAST_CYCLES)) i_gopc_core_monitor (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .rate_out_o(rate_out_o), .sample_strobe_o(sample_strobe_o), .queue_pop_i(queue_pop_i),
  .queue_data_valid_o(queue_data_valid_o), .queue_empty_o(queue_empty_o), .queue_full_o(queue_full_o));

// >>> test_gyro_output_path_config.sv
// test_gyro_output_path_config: self-checking bench of the output path block.
// assumes shortened tick counts (64/8/2); the host model drives the register port.
`timescale 1ns/1ns
module test_gyro_output_path_config
  import gopc_pkg::*;
;
  localparam int BASE = 64;
  localparam int MID = 8;
  localparam int FAST = 2;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] ramp = 16'h0000;
  logic [15:0] x_trim = 16'h0020;
  logic sync_pin = 1'b0;
  logic pop = 1'b0;
  logic pend = 1'b0;
  logic mode = 1'b0;
  gopc_sample_type raw, rate_out, q_data;
  gopc_reg_req_type req;
  logic [7:0] rdata, rd_v;
  logic strobe, q_valid, q_empty, q_full;
  logic [4:0] tags;
  gopc_sample_type exp_q[$];
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  time t0;
  // --------------------------------------------------------------------------
  // rows: address, write value, reset value, readback
  // --------------------------------------------------------------------------
  logic [7:0] rows [8][4] = '{'{GOPC_ADDR_Y_TRIM_HIGH, 8'hA5, 8'h00, 8'hA5},
    '{GOPC_ADDR_Y_TRIM_LOW, 8'h5A, 8'h00, 8'h5A}, '{GOPC_ADDR_Z_TRIM_HIGH, 8'hC3, 8'h00, 8'hC3},
    '{GOPC_ADDR_Z_TRIM_LOW, 8'h3C, 8'h00, 8'h3C}, '{GOPC_ADDR_DIVISOR, 8'h81, 8'h00, 8'h81},
    '{GOPC_ADDR_CONFIG, 8'hFF, 8'h00, 8'h7F}, '{GOPC_ADDR_RATE_CONFIG, 8'hFF, 8'h00, 8'h03},
    '{8'h40, 8'hFF, 8'h00, 8'h00}};
  // bypass bits, lowpass setting, divisor, strobe spacing in cycles
  int rate_rows [8][4] = '{'{1, 3, 5, FAST}, '{2, 0, 5, FAST}, '{3, 6, 9, FAST}, '{0, 0, 5, MID},
    '{0, 7, 5, MID}, '{0, 1, 2, 3 * BASE}, '{0, 2, 0, BASE}, '{0, 6, 1, 2 * BASE}};
  assign raw = '{ramp, 16'h7FF0, 16'h1234, 16'h0004};
  always #2 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) ramp <= ramp + 16'h0001;
  gopc_core #(.BASE_CYCLES(BASE), .MID_CYCLES(MID), .FAST_CYCLES(FAST), .QDEPTH(8)) i_gopc_core (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata), .raw_sample_i(raw),
    .x_rate_trim_i(x_trim), .frame_sync_input_i(sync_pin), .rate_out_o(rate_out), .sample_strobe_o(strobe),
    .queue_pop_i(pop), .queue_data_o(q_data), .queue_data_valid_o(q_valid), .queue_empty_o(q_empty),
    .queue_full_o(q_full));
  gopc_host_model i_gopc_host_model (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata), .reg_req_o(req));
  // --------------------------------------------------------------------------
  // queue reference: records each refreshed output, applies the full policy
  // --------------------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    #1;
    if (!rst_n_i) begin
      exp_q.delete();
      pend = 1'b0;
    end else begin
      if (pend && exp_q.size() == 8 && !mode) void'(exp_q.pop_front());
      if (pend && exp_q.size() < 8) exp_q.push_back(rate_out);
      pend = strobe;
    end
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      $display("ERROR %0t: timeout", $time);
      wrap_up();
    end
  end
  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic do_reset();
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic wait_strobe();
    @(posedge ref_clk_i);
    #1;
    while (strobe !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask
  task automatic pop_one(input logic want);
    gopc_sample_type e;
    @(posedge ref_clk_i);
    pop <= 1'b1;
    @(posedge ref_clk_i);
    pop <= 1'b0;
    #1;
    chk(q_valid, want, "pop valid");
    if (want) begin
      e = exp_q.pop_front();
      chk(q_data, e, "pop data");
    end
  endtask
  task automatic wrap_up();
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    do_reset();
    for (int i = 0; i < 8; i++) begin
      i_gopc_host_model.read(rows[i][0], rd_v);
      chk(rd_v, rows[i][2], "reset value");
      i_gopc_host_model.write(rows[i][0], rows[i][1]);
      i_gopc_host_model.read(rows[i][0], rd_v);
      chk(rd_v, rows[i][3], "readback");
    end
    // pass-through path so the sum is exact; trims chosen to wrap
    i_gopc_host_model.write(GOPC_ADDR_RATE_CONFIG, 8'h01);
    i_gopc_host_model.write(GOPC_ADDR_CONFIG, 8'h00);
    i_gopc_host_model.write(GOPC_ADDR_Y_TRIM_HIGH, 8'hFF);
    i_gopc_host_model.write(GOPC_ADDR_Y_TRIM_LOW, 8'h00);
    i_gopc_host_model.write(GOPC_ADDR_Z_TRIM_HIGH, 8'hFF);
    i_gopc_host_model.write(GOPC_ADDR_Z_TRIM_LOW, 8'hFA);
    repeat (2) wait_strobe();
    @(posedge ref_clk_i);
    #1;
    chk(rate_out.x, 16'h8010, "x trim");
    chk(rate_out.y, 16'h1134, "y trim");
    chk(rate_out.z, 16'hFFFE, "z trim");
    for (int s = 0; s < 5; s++) begin
      i_gopc_host_model.write(GOPC_ADDR_CONFIG, 8'(s << 3));
      for (int p = 1; p >= 0; p--) begin
        @(posedge ref_clk_i);
        sync_pin <= p[0];
        repeat (6) wait_strobe();
        @(posedge ref_clk_i);
        #1;
        tags = {rate_out.z[0], rate_out.y[0], rate_out.x[0], rate_out.temp[0], 1'b0};
        if (s > 0) chk(tags[s], p[0], "sync tag");
        else chk(tags[2], 1'b0, "untagged x");
      end
    end
    for (int r = 0; r < 8; r++) begin
      i_gopc_host_model.write(GOPC_ADDR_RATE_CONFIG, 8'(rate_rows[r][0]));
      i_gopc_host_model.write(GOPC_ADDR_CONFIG, 8'(rate_rows[r][1]));
      i_gopc_host_model.write(GOPC_ADDR_DIVISOR, 8'(rate_rows[r][2]));
      repeat (2) wait_strobe();
      t0 = $time;
      wait_strobe();
      chk(64'(($time - t0) / 4), 64'(rate_rows[r][3]), "strobe spacing");
    end
    // a second pin toggle before the strobe is ignored; the strobe then re-latches it
    i_gopc_host_model.write(GOPC_ADDR_CONFIG, 8'h16);
    wait_strobe();
    @(posedge ref_clk_i);
    sync_pin <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    sync_pin <= 1'b0;
    wait_strobe();
    @(posedge ref_clk_i);
    #1;
    chk(rate_out.x[0], 1'b1, "held sync");
    wait_strobe();
    @(posedge ref_clk_i);
    #1;
    chk(rate_out.x[0], 1'b0, "relatched sync");
    for (int m = 0; m < 2; m++) begin
      do_reset();
      mode = m[0];
      i_gopc_host_model.write(GOPC_ADDR_CONFIG, {1'b0, m[0], 6'h01});
      repeat (10) wait_strobe();
      chk(q_full, 1'b1, "queue full");
      i_gopc_host_model.read(GOPC_ADDR_QUEUE_STATUS, rd_v);
      chk(rd_v, 8'h08, "queue count");
      for (int k = 0; k < 8; k++) pop_one(1'b1);
      chk(q_empty, 1'b1, "queue drained");
      pop_one(1'b0);
    end
    wrap_up();
  end
endmodule
